/* File: common/sfe_map.svh */
// Constants for the serial flash front end: geometry and page limits.
// Assumes inclusion by the package and the top module of this block.
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH
`define SFE_PAGE_BYTES 256
`define SFE_PAGES_PER_SECTOR 1024
`define SFE_SECTORS 64
`define SFE_ADDR_BITS 24
`define SFE_PAGE_BITS 8
`define SFE_SECTOR_LSB 18
`define SFE_CMD_BULK_ERASE 8'hC7
`define SFE_CMD_SECTOR_ERASE 8'hD8
`define SFE_CMD_PAGE_PROGRAM 8'h02
`define SFE_CMD_READ 8'h03
`endif

/* File: common/sfe_pkg.sv */
// Types shared by the serial flash front end.
// Assumes the constants header sits beside it on the include path.
`include "sfe_map.svh"
package sfe_pkg;
   typedef enum logic [3:0] {
      SFE_IDLE = 4'b0001,
      SFE_CMD = 4'b0010,
      SFE_ADDR = 4'b0100,
      SFE_DATA = 4'b1000
   } sfe_state_type;

   // Request handed to the array side.
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic fast;
   } sfe_req_type;
endpackage

/* File: rtl/sfe_front_end.sv */
// Serial flash front end: pin sampling, framing, shifting and pause logic.
// Assumes ref_clk is much faster than the serial clock and the array is outside.
`timescale 1ns/1ns
`default_nettype none
`include "sfe_map.svh"
// How it works
// RQ1: Serial output changes only after a sampled falling serial clock edge.
// RQ2: Input bits are captured on sampled rising serial clock edges.
// RQ3: Instruction, address and program data all enter on the serial input.
// RQ4: Chip select high deselects and floats the serial output.
// RQ5: Standby is reported only when deselected and no internal cycle runs.
// RQ6: Chip select low selects the device and makes it active.
// RQ7: Serial activity is ignored until the first chip select falling edge.
// RQ8: Pause freezes the transfer state without deselecting.
// RQ9: During a pause output floats and input and clock are ignored.
// RQ10: Master starts a pause only while selected.
// RQ11: Logic level protect pin freezes block protect bits.
// RQ12: High program voltage flag selects accelerated program and erase.
// RQ13: Master keeps high voltage stable until the internal cycle ends.
// RQ14: Both idle-low and idle-high clock modes are accepted.
// RQ15: Idle clock level is the only difference between the modes.
// RQ16: Master keeps the serial clock below the maximum rate.
// RQ17: Page program takes 1 to 256 data bytes.
// RQ18: Addresses split into sector, page and byte fields.
// RQ19: Bulk erase and sector erase are both decoded.
// RQ20: Master drives protect and pause inputs to defined levels.
// RQ21: All bytes shift most significant bit first.
module sfe_front_end
   import sfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic serClk,
   input wire logic serIn,
   input wire logic chipSelN,
   input wire logic pauseN,
   input wire logic writeProtN,
   input wire logic highProgramVoltage,
   input wire logic [2:0] blockProtectBits,
   input wire logic busyIn,
   input wire logic [7:0] rdByte,
   output logic serOut,
   output logic serOutEn,
   output logic standby,
   output logic fastMode,
   output logic [2:0] frozenBp,
   output logic reqValid,
   output sfe_req_type req,
   output logic wrValid,
   output logic [7:0] wrByte,
   output logic [8:0] wrCount,
   output logic eraseBulk,
   output logic eraseSector,
   output logic [5:0] eraseSectorNum
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree.
   logic [2:0] clkS_r, sdiS_r, csS_r, hldS_r, wpS_r, vppS_r;
   logic clkF_r, csF_r, hldF_r, wpF_r, vppF_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clkS_r <= 3'h0; sdiS_r <= 3'h0; csS_r <= 3'h0; // A select held since power-up is no edge.
         hldS_r <= 3'h7; wpS_r <= 3'h7; vppS_r <= 3'h0;
      end else begin
         clkS_r <= {clkS_r[1:0], serClk};
         sdiS_r <= {sdiS_r[1:0], serIn};
         csS_r <= {csS_r[1:0], chipSelN};
         hldS_r <= {hldS_r[1:0], pauseN};
         wpS_r <= {wpS_r[1:0], writeProtN};
         vppS_r <= {vppS_r[1:0], highProgramVoltage};
      end
   end

   // Filtered levels: update only when stages two and three agree.
   function automatic logic filt(input logic [2:0] s, input logic old);
      filt = (s[1] == s[2]) ? s[2] : old;
   endfunction
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clkF_r <= 1'b0; csF_r <= 1'b0; hldF_r <= 1'b1; // Only a real high-to-low select arms.
         wpF_r <= 1'b1; vppF_r <= 1'b0;
      end else begin
         clkF_r <= filt(clkS_r, clkF_r);
         csF_r <= filt(csS_r, csF_r);
         hldF_r <= filt(hldS_r, hldF_r);
         wpF_r <= filt(wpS_r, wpF_r);
         vppF_r <= filt(vppS_r, vppF_r);
      end
   end

   // ------------------------------------------------------------
   // Edge and pause decoding
   // ------------------------------------------------------------
   wire logic clkNow = filt(clkS_r, clkF_r);
   wire logic csNow = filt(csS_r, csF_r);
   wire logic rise = clkNow & ~clkF_r; // RQ2 RQ14
   wire logic fall = ~clkNow & clkF_r; // RQ1 RQ14
   wire logic csFall = ~csNow & csF_r;
   logic armed_r, paused_r;
   // Pause state changes only while the clock is low or on deselect, so a pause
   // entered mid-bit waits for the clock to go low first.
   wire logic paused_nxt = (csF_r | clkF_r) ? (paused_r & ~csF_r) : ~hldF_r; // RQ8 RQ10
   wire logic live = armed_r & ~csF_r & ~paused_r; // RQ6 RQ7 RQ9

   // ------------------------------------------------------------
   // Framing state machine
   // ------------------------------------------------------------
   sfe_state_type st_r;
   logic [2:0] bitCnt_r;
   logic [1:0] addrCnt_r;
   logic [7:0] shIn_r, shOut_r, op_r;
   logic [23:0] addr_r;
   wire logic [7:0] byteNow = {shIn_r[6:0], sdiS_r[2]}; // RQ21 RQ3
   wire logic byteDone = live & rise & (bitCnt_r == 3'h7);
   wire logic isProg = op_r == `SFE_CMD_PAGE_PROGRAM;
   wire logic isRead = op_r == `SFE_CMD_READ;
   wire logic needsAddr = (byteNow == `SFE_CMD_PAGE_PROGRAM) | (byteNow == `SFE_CMD_READ)
      | (byteNow == `SFE_CMD_SECTOR_ERASE);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed_r <= 1'b0; paused_r <= 1'b0; st_r <= SFE_IDLE;
         bitCnt_r <= 3'h0; addrCnt_r <= 2'h0; shIn_r <= 8'h00;
         op_r <= 8'h00; addr_r <= 24'h000000; shOut_r <= 8'h00;
         serOut <= 1'b0; serOutEn <= 1'b0; reqValid <= 1'b0;
         req <= '0; wrValid <= 1'b0; wrByte <= 8'h00; wrCount <= 9'h000;
         eraseBulk <= 1'b0; eraseSector <= 1'b0; eraseSectorNum <= 6'h00;
         standby <= 1'b1; fastMode <= 1'b0; frozenBp <= 3'h0;
      end else begin
         reqValid <= 1'b0; wrValid <= 1'b0; eraseBulk <= 1'b0; eraseSector <= 1'b0;
         if (csFall) armed_r <= 1'b1; // RQ7
         paused_r <= paused_nxt;
         standby <= csF_r & ~busyIn; // RQ5 RQ6
         fastMode <= vppF_r; // RQ12
         if (~wpF_r & ~vppF_r) begin
            frozenBp <= frozenBp; // RQ11
         end else begin
            frozenBp <= blockProtectBits;
         end
         serOutEn <= live & (st_r == SFE_DATA) & isRead; // RQ4 RQ9
         if (csF_r) begin
            st_r <= SFE_CMD; bitCnt_r <= 3'h0; wrCount <= 9'h000;
         end else if (live & rise) begin
            shIn_r <= byteNow;
            bitCnt_r <= bitCnt_r + 3'h1;
         end
         if (live & fall & (st_r == SFE_DATA) & isRead) begin
            serOut <= shOut_r[7]; // RQ1 RQ21
            shOut_r <= {shOut_r[6:0], 1'b0};
         end
         if (byteDone) begin
            unique case (st_r)
               SFE_IDLE, SFE_CMD: begin
                  op_r <= byteNow;
                  addrCnt_r <= 2'h0;
                  if (needsAddr) begin
                     st_r <= SFE_ADDR;
                  end else begin
                     st_r <= SFE_IDLE;
                     eraseBulk <= byteNow == `SFE_CMD_BULK_ERASE; // RQ19
                  end
               end
               SFE_ADDR: begin
                  addr_r <= {addr_r[15:0], byteNow};
                  addrCnt_r <= addrCnt_r + 2'h1;
                  if (addrCnt_r == 2'h2) begin
                     st_r <= (op_r == `SFE_CMD_SECTOR_ERASE) ? SFE_IDLE : SFE_DATA;
                     eraseSector <= op_r == `SFE_CMD_SECTOR_ERASE; // RQ19
                     eraseSectorNum <= addr_r[`SFE_SECTOR_LSB-3:`SFE_SECTOR_LSB-8]; // RQ18
                     reqValid <= 1'b1;
                     req <= '{opcode: op_r, addr: {addr_r[15:0], byteNow}, fast: vppF_r};
                     shOut_r <= rdByte;
                  end
               end
               SFE_DATA: begin
                  if (isProg & (wrCount != 9'(`SFE_PAGE_BYTES))) begin
                     wrValid <= 1'b1; // RQ17 RQ3
                     wrByte <= byteNow;
                     wrCount <= wrCount + 9'h001;
                  end
                  if (isRead) shOut_r <= rdByte;
               end
               default: st_r <= SFE_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_out_float;
      @(posedge ref_clk) disable iff (rst) (csF_r | paused_r) |=> !serOutEn;
   endproperty
   a_out_float: assert property (p_out_float) else $error("Output driven while deselected or paused."); // RQ4
   property p_out_edge;
      @(posedge ref_clk) disable iff (rst) $changed(serOut) |-> $past(fall);
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("Output changed without falling clock."); // RQ1
   property p_arm;
      @(posedge ref_clk) disable iff (rst) !armed_r |=> !reqValid && !wrValid;
   endproperty
   a_arm: assert property (p_arm) else $error("Activity before first select edge."); // RQ7
   property p_standby;
      @(posedge ref_clk) disable iff (rst) (!csF_r || busyIn) |=> !standby;
   endproperty
   a_standby: assert property (p_standby) else $error("Standby while busy or selected."); // RQ5
   property p_pause_hold;
      @(posedge ref_clk) disable iff (rst) (paused_r && !csF_r) |=> $stable(bitCnt_r);
   endproperty
   a_pause_hold: assert property (p_pause_hold) else $error("Bit count moved during pause."); // RQ9
   property p_count;
      @(posedge ref_clk) disable iff (rst) wrCount <= 9'(`SFE_PAGE_BYTES);
   endproperty
   a_count: assert property (p_count) else $error("Page byte count over limit."); // RQ17
   property p_fast;
      @(posedge ref_clk) disable iff (rst) vppF_r |=> fastMode;
   endproperty
   a_fast: assert property (p_fast) else $error("Fast mode not entered."); // RQ12
   property p_capture;
      @(posedge ref_clk) disable iff (rst) (live && rise && !csNow) |=> shIn_r[0] == $past(sdiS_r[2]);
   endproperty
   a_capture: assert property (p_capture) else $error("Input bit not captured on rise."); // RQ2
endmodule
`default_nettype wire

/* File: testbench/sfe_master_model.sv */
// Bus master model that drives the serial pins of the flash front end.
// Assumes ref_clk is the 50 MHz system clock; link half period is 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module sfe_master_model (
   input wire logic ref_clk,
   input wire logic serOut,
   input wire logic serOutEn,
   output logic serClk,
   output logic serIn,
   output logic chipSelN,
   output logic pauseN
);
   logic cpol = 1'b0;
   int pauseLeak = 0;
   // Pins start selected, so reset release gives no select edge.
   initial begin
      serClk = 1'b0;
      serIn = 1'b0;
      chipSelN = 1'b0;
      pauseN = 1'b1;
   end
   // Half of the 160 ns link period.
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask
   // The clock parks at the mode's idle level before the select edge.
   task automatic sel();
      serClk = cpol;
      half();
      chipSelN = 1'b0;
      half();
   endtask
   // Nobody holds the data line once deselected, so it drifts.
   task automatic desel();
      half();
      chipSelN = 1'b1;
      serIn = ~serIn;
      half();
   endtask
   // One byte each way, MSB first; a pause with stray clocking before bit pauseAt.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int pauseAt);
      for (int i = 7; i >= 0; i--) begin
         serClk = 1'b0;
         serIn = tx[i];
         half();
         if (i == pauseAt) begin
            pauseN = 1'b0;
            half();
            serClk = 1'b1;
            serIn = ~tx[i];
            half();
            // The pause pin passes the synchroniser first, so the float is judged late.
            if (serOutEn !== 1'b0) pauseLeak++;
            serClk = 1'b0;
            serIn = tx[i];
            pauseN = 1'b1;
            half();
         end
         serClk = 1'b1;
         rx[i] = serOut;
         half();
      end
      serClk = cpol;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial flash front end.
// Assumes the master model file and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import sfe_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic writeProtN = 1'b1, highProgramVoltage = 1'b0, busyIn = 1'b0;
   logic [2:0] blockProtectBits = 3'h0;
   logic [7:0] rdByte = 8'hA5, rx;
   wire logic serClk, serIn, chipSelN, pauseN;
   logic serOut, serOutEn, standby, fastMode, reqValid, wrValid, eraseBulk, eraseSector;
   logic [2:0] frozenBp;
   logic [7:0] wrByte;
   logic [8:0] wrCount;
   logic [5:0] eraseSectorNum, lastSec;
   sfe_req_type req, lastReq;
   int miscompares = 0, num_checks = 0, nWr = 0, nBulk = 0, nSec = 0, badWr = 0;
   always #10 ref_clk = ~ref_clk;
   sfe_master_model u_mst (.ref_clk(ref_clk), .serOut(serOut), .serOutEn(serOutEn), .serClk(serClk),
      .serIn(serIn), .chipSelN(chipSelN), .pauseN(pauseN));
   sfe_front_end u_dut (.ref_clk(ref_clk), .rst(rst), .serClk(serClk), .serIn(serIn), .chipSelN(chipSelN),
      .pauseN(pauseN), .writeProtN(writeProtN), .highProgramVoltage(highProgramVoltage),
      .blockProtectBits(blockProtectBits), .busyIn(busyIn), .rdByte(rdByte), .serOut(serOut),
      .serOutEn(serOutEn), .standby(standby), .fastMode(fastMode), .frozenBp(frozenBp),
      .reqValid(reqValid), .req(req), .wrValid(wrValid), .wrByte(wrByte), .wrCount(wrCount),
      .eraseBulk(eraseBulk), .eraseSector(eraseSector), .eraseSectorNum(eraseSectorNum));
   // Pulse monitor; program bytes are expected to carry their own index.
   always @(posedge ref_clk) begin
      if (wrValid === 1'b1) begin
         if (wrByte !== nWr[7:0]) badWr++;
         nWr++;
      end
      if (reqValid === 1'b1) lastReq <= req;
      if (eraseBulk === 1'b1) nBulk++;
      if (eraseSector === 1'b1) begin
         nSec++;
         lastSec <= eraseSectorNum;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic summarize();
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Bits before the first select edge must be dropped, then bulk erase.
   task automatic t_arm();
      u_mst.xfer(8'hC7, rx, -1);
      u_mst.desel();
      chk(nBulk, 0);
      u_mst.sel();
      u_mst.xfer(8'hC7, rx, -1);
      u_mst.desel();
      chk(nBulk, 1);
   endtask
   // Sector erase: the sector number is the top six address bits.
   task automatic t_sector();
      u_mst.sel();
      u_mst.xfer(8'hD8, rx, -1);
      u_mst.xfer(8'hAB, rx, -1);
      u_mst.xfer(8'hCD, rx, -1);
      u_mst.xfer(8'hEF, rx, -1);
      u_mst.desel();
      chk(nSec, 1);
      chk(lastSec, 6'h2A);
   endtask
   // One byte past a full page is sent; it must be refused.
   task automatic t_program();
      highProgramVoltage = 1'b1;
      u_mst.sel();
      u_mst.xfer(8'h02, rx, -1);
      u_mst.xfer(8'h12, rx, -1);
      u_mst.xfer(8'h34, rx, -1);
      u_mst.xfer(8'h00, rx, -1);
      for (int i = 0; i < 257; i++) u_mst.xfer(i[7:0], rx, -1);
      // Deselect clears the byte count, so it is read while still selected.
      chk(wrCount, 9'h100);
      u_mst.desel();
      chk(nWr, 256);
      chk(badWr, 0);
      chk(lastReq.opcode, 8'h02);
      chk(lastReq.addr, 24'h123400);
      chk(lastReq.fast, 1'b1);
      chk(fastMode, 1'b1);
      highProgramVoltage = 1'b0;
   endtask
   // Idle-high read with a pause and stray clocking inside the data byte.
   task automatic t_read();
      u_mst.cpol = 1'b1;
      u_mst.sel();
      u_mst.xfer(8'h03, rx, -1);
      u_mst.xfer(8'h00, rx, -1);
      u_mst.xfer(8'h01, rx, -1);
      u_mst.xfer(8'h02, rx, -1);
      u_mst.xfer(8'hFF, rx, 3);
      chk(rx, 8'hA5);
      chk(u_mst.pauseLeak, 0);
      u_mst.desel();
      // The select pin is synchronised, so the float follows a few cycles later.
      w(4);
      chk(serOutEn, 1'b0);
   endtask
   // Standby waits for the internal cycle; selection makes it active.
   task automatic t_power();
      busyIn = 1'b1;
      w(8);
      chk(standby, 1'b0);
      busyIn = 1'b0;
      w(8);
      chk(standby, 1'b1);
      u_mst.sel();
      w(8);
      chk(standby, 1'b0);
      u_mst.desel();
   endtask
   // A low protect pin must hold the protect bits against later changes.
   task automatic t_protect();
      blockProtectBits = 3'h5;
      w(8);
      chk(frozenBp, 3'h5);
      writeProtN = 1'b0;
      w(6);
      blockProtectBits = 3'h2;
      w(8);
      chk(frozenBp, 3'h5);
   endtask
   initial begin
      w(5);
      rst = 1'b0;
      w(2);
      t_arm();
      t_sector();
      t_program();
      t_read();
      t_power();
      t_protect();
      summarize();
   end
   // The full run is near 350 us; this limit leaves ample margin.
   initial begin
      #1500000;
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
